// [csw_defines.svh]
/*
  Register indices, field positions and reset values of the chip select
  and wait-state unit.
  Assumes it is included by its bare name from the unit's source files.
*/
`ifndef CSW_DEFINES_SVH
`define CSW_DEFINES_SVH

// register indices, byte address is four times the index
`define CSW_IDX_UPPER_MEMORY_SELECT_CFG 8'hA0
`define CSW_IDX_LOWER_MEMORY_SELECT_CFG 8'hA2
`define CSW_IDX_PERIPHERAL_SELECT_BASE 8'hA4
`define CSW_IDX_MIDRANGE_SELECT_CFG 8'hA6
`define CSW_IDX_SELECT_AUXILIARY_CFG 8'hA8
`define CSW_IDX_SYS 8'hAA
`define CSW_IDX_STAT 8'hAC

// reset values
`define CSW_RST_UPPER_MEMORY_SELECT_CFG 16'hF03B
`define CSW_RST_ZERO 16'h0000

// field positions
`define CSW_BIT_RDY_IGN 2
`define CSW_BIT_WAIT_HI 3
`define CSW_BIT_DA 7
`define CSW_BIT_MEMSP 7
`define CSW_BIT_A21 6
`define CSW_BIT_MSINGLE 14

// peripheral block is 256 bytes
`define CSW_PER_LOG2 8

// bus answers
`define CSW_RESP_OK 2'h0
`define CSW_RESP_ERR 2'h2

`endif

// [csw_pkg.sv]
/*
  Types of the chip select and wait-state unit.
  Assumes nothing of its surroundings.
*/
package csw_pkg;

  // one bus cycle presented by the core or the dma unit
  typedef struct packed {
    logic [19:0] addr;
    logic isIo;
  } csw_cyc_s;

  // ready and wait programming picked for one cycle
  typedef struct packed {
    logic readyIgnore;
    logic [3:0] waits;
  } csw_cfg_s;

  // bus cycle phases
  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_T2 = 3'b001,
    S_T3 = 3'b010,
    S_WAIT = 3'b011,
    S_HOLD = 3'b100,
    S_LAST = 3'b101,
    S_T4 = 3'b110
  } csw_state_e;

endpackage

// [csw_sync.sv]
/*
  Two flip-flop synchroniser for pin inputs.
  Assumes the inputs are levels from outside the clock domain.
*/
`timescale 1ns/10ps
`default_nettype none
module csw_sync #(
  parameter int W = 2
) (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [W-1:0] din,
  output logic [W-1:0] dout
);

  logic [W-1:0] stage1;

  // first stage feeds only the second
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      stage1 <= '0;
      dout <= '0;
    end else begin
      stage1 <= din;
      dout <= stage1;
    end
  end

endmodule
`default_nettype wire

// [csw_wait_gen.sv]
/*
  Wait-state and ready sequencer for one bus cycle.
  Assumes start comes from logic on the same clock, ready is synchronised.
*/
`timescale 1ns/10ps
`default_nettype none
module csw_wait_gen (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic start,
  input wire csw_pkg::csw_cfg_s cfg,
  input wire logic ready,
  output logic done,
  output logic busy
);

  csw_pkg::csw_state_e state;
  csw_pkg::csw_cfg_s cfgQ;
  logic [3:0] cnt;
  logic first;
  logic rdyOk;

  assign rdyOk = cfgQ.readyIgnore | ready;
  assign done = (state == csw_pkg::S_T4);
  assign busy = (state != csw_pkg::S_IDLE);

  // programming is frozen for the whole cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      cfgQ <= '0;
    end else if (start && !busy) begin
      cfgQ <= cfg;
    end
  end

  // programmed waits run out first only if ready is seen at the first wait; otherwise the count stops and ready is awaited
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state <= csw_pkg::S_IDLE;
      cnt <= 4'h0;
      first <= 1'b0;
    end else begin
      unique case (state)
        csw_pkg::S_IDLE: begin
          if (start) begin
            state <= csw_pkg::S_T2;
          end
        end
        csw_pkg::S_T2: begin
          state <= csw_pkg::S_T3;
        end
        csw_pkg::S_T3: begin
          cnt <= cfgQ.waits;
          first <= 1'b1;
          if (cfgQ.waits != 4'h0) begin
            state <= csw_pkg::S_WAIT; // [R11]
          end else if (rdyOk) begin
            state <= csw_pkg::S_T4;
          end else begin
            state <= csw_pkg::S_HOLD;
          end
        end
        csw_pkg::S_WAIT: begin
          first <= 1'b0;
          cnt <= cnt - 4'h1;
          if (first && !rdyOk) begin
            state <= csw_pkg::S_HOLD; // [R12]
          end else if (cnt == 4'h1) begin
            state <= csw_pkg::S_T4; // [R11]
          end
        end
        csw_pkg::S_HOLD: begin
          if (ready) begin
            state <= csw_pkg::S_LAST; // [R12]
          end
        end
        csw_pkg::S_LAST: begin
          state <= csw_pkg::S_T4;
        end
        csw_pkg::S_T4: begin
          state <= csw_pkg::S_IDLE;
        end
        default: begin
          state <= csw_pkg::S_IDLE;
        end
      endcase
    end
  end

  property p_zero_wait;
    @(posedge clock) disable iff (!arst_n)
      (start && !busy && cfg.readyIgnore && cfg.waits == 4'h0) |-> ##3 done;
  endproperty
  a_zero_wait: assert property (p_zero_wait) else $error("zero-wait cycle length wrong"); // [R9]

  property p_two_wait;
    @(posedge clock) disable iff (!arst_n)
      (start && !busy && cfg.readyIgnore && cfg.waits == 4'h2) |-> !done [*5] ##1 done;
  endproperty
  a_two_wait: assert property (p_two_wait) else $error("two-wait cycle not six long"); // [R9]

  property p_fifteen_wait;
    @(posedge clock) disable iff (!arst_n)
      (start && !busy && cfg.readyIgnore && cfg.waits == 4'hF) |-> ##18 done;
  endproperty
  a_fifteen_wait: assert property (p_fifteen_wait) else $error("fifteen waits wrong"); // [R10]

  property p_hold_tail;
    @(posedge clock) disable iff (!arst_n)
      (state == csw_pkg::S_HOLD && ready) |=> !done ##1 done;
  endproperty
  a_hold_tail: assert property (p_hold_tail) else $error("no extra wait after ready"); // [R12]

  property p_ignore_no_hold;
    @(posedge clock) disable iff (!arst_n)
      cfgQ.readyIgnore |-> state != csw_pkg::S_HOLD;
  endproperty
  a_ignore_no_hold: assert property (p_ignore_no_hold) else $error("ready waited when ignored"); // [R8]

endmodule
`default_nettype wire

// [csw_chip_select.sv]
/*
  Chip select and wait-state unit: decodes each bus cycle into upper,
  lower, midrange and peripheral selects, and runs the wait sequence.
  Assumes an AXI4-Lite master for the registers, a core or dma cycle
  source on the same clock, and ready pins from outside the clock domain.
*/
// The implementer's own choice: register access over AXI4-Lite.
`timescale 1ns/10ps
`default_nettype none
`include "csw_defines.svh"
// How it works
// [R1] Selects assert on any cycle in range, core or dma alike.
// [R2] Each peripheral select decodes one 256-byte block from a programmable base.
// [R3] Upper range always ends at top of memory; only its start is set.
// [R4] Lower range always starts at zero; only its end is set.
// [R5] Upper active from reset; others wait for their register writes.
// [R6] Upper and lower selects assert early, with the plain address.
// [R7] Midrange and peripheral selects assert one cycle later, with the muxed bus.
// [R8] Ready-ignore bit set skips external ready; clear requires it.
// [R9] Two-bit wait field inserts zero to three wait states.
// [R10] Low four peripheral selects add a high wait bit, up to fifteen.
// [R11] Programmed waits always finish before external ready counts; here ready missing at the first wait stops the count.
// [R12] Ready sampled at first wait; if late, one extra wait follows ready.
// [R13] Async ready rising edge is accepted with no clock relation.
// [R14] Software gives overlapping selects identical ready and wait settings.
// [R15] Software gives a peripheral select over dram at least the dram waits.
// [R16] On-chip register block acts as zero waits, ready ignored.
// [R17] Address-disable on upper or lower suppresses the address phase.
// [R18] Midrange and peripheral wait logic works even when pins are i/o.
// [R19] Pinless fifth peripheral select still drives ready and wait logic.
// [R20] High peripheral pins carrying address bits lose their wait logic.
// [R21] Peripheral over dram keeps row strobe, blocks both column strobes.
// [R22] Software programs dram width for a peripheral over dram.
// [R23] Single-select bit makes the first midrange select cover all.
// [R24] After reset upper covers top 64K, ready required, three waits.
module csw_chip_select (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic cycStart,
  input wire csw_pkg::csw_cyc_s cycReq,
  input wire logic pcbHit,
  input wire logic dramHit,
  input wire logic asyncReady,
  input wire logic syncReady,
  output logic cycDone,
  output logic cycBusy,
  output logic upperSelN,
  output logic lowerSelN,
  output logic [3:0] midSelN,
  output logic [3:0] lowPeriphSelN,
  output logic [1:0] highPeriphSelN,
  output logic addrPhaseSuppress,
  output logic colStrobeInhibit
);

  ////////////////////////////////////////////////////////////////////////
  // registers

  logic [15:0] upper_memory_select_cfg;
  logic [15:0] lower_memory_select_cfg;
  logic [15:0] peripheral_select_base;
  logic [15:0] midrange_select_cfg;
  logic [15:0] select_auxiliary_cfg;
  logic midSingle;
  logic umActive;
  logic lmActive;
  logic mmWritten;
  logic mpWritten;
  logic paWritten;
  logic midActive;
  logic perActive;

  logic awHeld;
  logic wHeld;
  logic [11:0] awAddrQ;
  logic [15:0] wDataQ;
  logic [1:0] wStrbQ;
  logic wrEn;
  logic [7:0] wrIdx;
  logic wrHit;
  logic [7:0] rdIdx;
  logic [15:0] rdVal;
  logic rdHit;

  // byte-lane merge for the low half word
  function automatic logic [15:0] merge(input logic [15:0] old,
                                        input logic [15:0] data,
                                        input logic [1:0] strb);
    merge = {strb[1] ? data[15:8] : old[15:8], strb[0] ? data[7:0] : old[7:0]};
  endfunction

  assign s_axi_awready = !awHeld && !s_axi_bvalid;
  assign s_axi_wready = !wHeld && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign wrEn = awHeld && wHeld && !s_axi_bvalid;
  assign wrIdx = awAddrQ[9:2];
  assign rdIdx = s_axi_araddr[9:2];

  // address and data may come in either order
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      awAddrQ <= 12'h000;
      wDataQ <= `CSW_RST_ZERO;
      wStrbQ <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        awAddrQ <= s_axi_awaddr;
      end else if (wrEn) begin
        awHeld <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wDataQ <= s_axi_wdata[15:0];
        wStrbQ <= s_axi_wstrb[1:0];
      end else if (wrEn) begin
        wHeld <= 1'b0;
      end
    end
  end

  // writable register decode, the status word is read only
  always_comb begin
    wrHit = 1'b0;
    if (awAddrQ[11:10] == 2'h0 && awAddrQ[1:0] == 2'h0) begin
      unique case (wrIdx)
        `CSW_IDX_UPPER_MEMORY_SELECT_CFG, `CSW_IDX_LOWER_MEMORY_SELECT_CFG, `CSW_IDX_PERIPHERAL_SELECT_BASE, `CSW_IDX_MIDRANGE_SELECT_CFG, `CSW_IDX_SELECT_AUXILIARY_CFG,
        `CSW_IDX_SYS: wrHit = 1'b1;
        default: wrHit = 1'b0;
      endcase
    end
  end

  // write response, one outstanding write
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CSW_RESP_OK;
    end else if (wrEn) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wrHit ? `CSW_RESP_OK : `CSW_RESP_ERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // configuration storage; upper reset value gives boot range
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      upper_memory_select_cfg <= `CSW_RST_UPPER_MEMORY_SELECT_CFG; // [R24]
      lower_memory_select_cfg <= `CSW_RST_ZERO;
      peripheral_select_base <= `CSW_RST_ZERO;
      midrange_select_cfg <= `CSW_RST_ZERO;
      select_auxiliary_cfg <= `CSW_RST_ZERO;
      midSingle <= 1'b0;
    end else if (wrEn && wrHit) begin
      unique case (wrIdx)
        `CSW_IDX_UPPER_MEMORY_SELECT_CFG: upper_memory_select_cfg <= merge(upper_memory_select_cfg, wDataQ, wStrbQ);
        `CSW_IDX_LOWER_MEMORY_SELECT_CFG: lower_memory_select_cfg <= merge(lower_memory_select_cfg, wDataQ, wStrbQ);
        `CSW_IDX_PERIPHERAL_SELECT_BASE: peripheral_select_base <= merge(peripheral_select_base, wDataQ, wStrbQ);
        `CSW_IDX_MIDRANGE_SELECT_CFG: midrange_select_cfg <= merge(midrange_select_cfg, wDataQ, wStrbQ);
        `CSW_IDX_SELECT_AUXILIARY_CFG: select_auxiliary_cfg <= merge(select_auxiliary_cfg, wDataQ, wStrbQ);
        default: begin
          if (wStrbQ[1]) begin
            midSingle <= wDataQ[`CSW_BIT_MSINGLE];
          end
        end
      endcase
    end
  end

  // activation flags: upper set from reset, lower by its first write, midrange and peripheral once their own and the auxiliary register are written; held
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      umActive <= 1'b1; // [R5]
      lmActive <= 1'b0;
      mmWritten <= 1'b0;
      mpWritten <= 1'b0;
      paWritten <= 1'b0;
    end else if (wrEn && wrHit) begin
      if (wrIdx == `CSW_IDX_LOWER_MEMORY_SELECT_CFG) begin
        lmActive <= 1'b1; // [R5]
      end
      if (wrIdx == `CSW_IDX_MIDRANGE_SELECT_CFG) begin
        mmWritten <= 1'b1;
      end
      if (wrIdx == `CSW_IDX_SELECT_AUXILIARY_CFG) begin
        mpWritten <= 1'b1;
      end
      if (wrIdx == `CSW_IDX_PERIPHERAL_SELECT_BASE) begin
        paWritten <= 1'b1;
      end
    end
  end

  assign midActive = mmWritten && mpWritten; // [R5]
  assign perActive = paWritten && mpWritten; // [R5]

  // read mux
  always_comb begin
    rdHit = (s_axi_araddr[11:10] == 2'h0) && (s_axi_araddr[1:0] == 2'h0);
    unique case (rdIdx)
      `CSW_IDX_UPPER_MEMORY_SELECT_CFG: rdVal = upper_memory_select_cfg;
      `CSW_IDX_LOWER_MEMORY_SELECT_CFG: rdVal = lower_memory_select_cfg;
      `CSW_IDX_PERIPHERAL_SELECT_BASE: rdVal = peripheral_select_base;
      `CSW_IDX_MIDRANGE_SELECT_CFG: rdVal = midrange_select_cfg;
      `CSW_IDX_SELECT_AUXILIARY_CFG: rdVal = select_auxiliary_cfg;
      `CSW_IDX_SYS: rdVal = {1'b0, midSingle, 14'h0000};
      `CSW_IDX_STAT: rdVal = {11'h000, cycBusy, perActive, midActive, lmActive, umActive};
      default: begin
        rdVal = `CSW_RST_ZERO;
        rdHit = 1'b0;
      end
    endcase
  end

  // read answer one cycle after the address is taken
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `CSW_RESP_OK;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= {16'h0000, rdVal};
      s_axi_rresp <= rdHit ? `CSW_RESP_OK : `CSW_RESP_ERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // address decode

  logic upperHit;
  logic lowerHit;
  logic midMatch;
  logic [6:0] midDiff;
  logic [2:0] midExp;
  logic [8:0] midQuarter;
  logic [3:0] midHit;
  logic perMatch;
  logic perSpaceOk;
  logic [6:0] perHit;
  logic a21Mode;

  // upper ends at the top, lower starts at zero, both memory only
  assign upperHit = umActive && !cycReq.isIo && cycReq.addr[19] &&
                    ((cycReq.addr[18:16] & upper_memory_select_cfg[14:12]) == upper_memory_select_cfg[14:12]); // [R3]
  assign lowerHit = lmActive && !cycReq.isIo && !cycReq.addr[19] &&
                    ((cycReq.addr[18:16] & ~lower_memory_select_cfg[14:12]) == 3'h0); // [R4]

  // midrange block: base in 8K units, size as a power of two
  assign midExp = select_auxiliary_cfg[10:8];
  assign midDiff = (cycReq.addr[19:13] ^ midrange_select_cfg[15:9]) >> midExp;
  assign midMatch = midActive && !cycReq.isIo && (midDiff == 7'h00);
  assign midQuarter = cycReq.addr[19:11] >> midExp;

  // peripheral blocks sit back to back above the base
  assign a21Mode = select_auxiliary_cfg[`CSW_BIT_A21];
  assign perSpaceOk = select_auxiliary_cfg[`CSW_BIT_MEMSP] ? !cycReq.isIo : cycReq.isIo;
  assign perMatch = perActive && perSpaceOk && (cycReq.addr[19:11] == peripheral_select_base[15:7]);

  genvar gi;
  generate
    for (gi = 0; gi < 7; gi++) begin : g_per
      assign perHit[gi] = perMatch &&
                          (cycReq.addr[`CSW_PER_LOG2 +: 3] == 3'(gi)); // [R2]
    end
    for (gi = 0; gi < 4; gi++) begin : g_mid
      // single-select mode folds all quarters onto the first select
      assign midHit[gi] = midMatch &&
                          (midSingle ? (gi == 0) : (midQuarter[1:0] == 2'(gi))); // [R23]
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // ready and wait selection

  csw_pkg::csw_cfg_s cycCfg;
  logic [1:0] readySync;
  logic readyAny;

  // overlapping selects are assumed to carry equal settings, so first hit wins
  always_comb begin
    cycCfg.readyIgnore = 1'b1;
    cycCfg.waits = 4'h0;
    if (pcbHit) begin
      cycCfg.readyIgnore = 1'b1; // [R16]
      cycCfg.waits = 4'h0; // [R16]
    end else if (upperHit) begin
      cycCfg = {upper_memory_select_cfg[`CSW_BIT_RDY_IGN], 2'h0, upper_memory_select_cfg[1:0]}; // [R8] [R9]
    end else if (lowerHit) begin
      cycCfg = {lower_memory_select_cfg[`CSW_BIT_RDY_IGN], 2'h0, lower_memory_select_cfg[1:0]};
    end else if (|midHit || midMatch) begin
      cycCfg = {midrange_select_cfg[`CSW_BIT_RDY_IGN], 2'h0, midrange_select_cfg[1:0]}; // [R18]
    end else if (|perHit[3:0]) begin
      // high wait bit stretches the two-bit field to 3, 7, 11 or 15 waits
      cycCfg = {peripheral_select_base[`CSW_BIT_RDY_IGN],
                peripheral_select_base[`CSW_BIT_WAIT_HI] ? {peripheral_select_base[1:0], 2'b11} : {2'b00, peripheral_select_base[1:0]}}; // [R10]
    end else if (perHit[4] || (|perHit[6:5] && !a21Mode)) begin
      cycCfg = {select_auxiliary_cfg[`CSW_BIT_RDY_IGN], 2'h0, select_auxiliary_cfg[1:0]}; // [R19] [R20]
    end
  end

  // both ready pins pass two flops before use
  csw_sync #(.W(2)) u_sync (
    .clock(clock),
    .arst_n(arst_n),
    .din({syncReady, asyncReady}),
    .dout(readySync)
  );
  assign readyAny = |readySync; // [R13]

  csw_wait_gen u_wait (
    .clock(clock),
    .arst_n(arst_n),
    .start(cycStart),
    .cfg(cycCfg),
    .ready(readyAny),
    .done(cycDone),
    .busy(cycBusy)
  );

  ////////////////////////////////////////////////////////////////////////
  // select outputs

  logic cycTake;
  logic muxPhase;
  logic [3:0] midQ;
  logic [6:0] perQ;
  logic [1:0] addrLow;
  logic dramQ;
  logic daUpper;
  logic daLower;

  assign cycTake = cycStart && !cycBusy;

  // early selects follow the plain address from the first cycle
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      upperSelN <= 1'b1;
      lowerSelN <= 1'b1;
      daUpper <= 1'b0;
      daLower <= 1'b0;
    end else if (cycTake) begin
      upperSelN <= !upperHit; // [R1] [R6]
      lowerSelN <= !lowerHit; // [R6]
      daUpper <= upperHit && upper_memory_select_cfg[`CSW_BIT_DA];
      daLower <= lowerHit && lower_memory_select_cfg[`CSW_BIT_DA];
    end else if (cycDone) begin
      upperSelN <= 1'b1;
      lowerSelN <= 1'b1;
      daUpper <= 1'b0;
      daLower <= 1'b0;
    end
  end

  // late decode held one cycle so the muxed-bus selects lag by one
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      muxPhase <= 1'b0;
      midQ <= 4'h0;
      perQ <= 7'h00;
      addrLow <= 2'h0;
      dramQ <= 1'b0;
    end else if (cycTake) begin
      muxPhase <= 1'b1;
      midQ <= midHit;
      perQ <= perHit;
      addrLow <= cycReq.addr[2:1];
      dramQ <= dramHit;
    end else begin
      muxPhase <= 1'b0;
    end
  end

  // muxed-bus selects; high pair may carry latched address bits instead
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      midSelN <= 4'hF;
      lowPeriphSelN <= 4'hF;
      highPeriphSelN <= 2'h3;
    end else if (muxPhase) begin
      midSelN <= ~midQ; // [R7]
      lowPeriphSelN <= ~perQ[3:0]; // [R7]
      highPeriphSelN <= a21Mode ? addrLow : ~perQ[6:5]; // [R20]
    end else if (cycDone) begin
      midSelN <= 4'hF;
      lowPeriphSelN <= 4'hF;
      highPeriphSelN <= a21Mode ? addrLow : 2'h3;
    end
  end

  // upper or lower select with address-disable set drops the address phase
  assign addrPhaseSuppress = daUpper || daLower; // [R17]
  // row strobe is left to the dram side; columns blocked for peripherals
  assign colStrobeInhibit = dramQ && (|perQ) && cycBusy; // [R21]

  ////////////////////////////////////////////////////////////////////////
  // checks

  property p_lower_off;
    @(posedge clock) disable iff (!arst_n)
      !lmActive |-> lowerSelN;
  endproperty
  a_lower_off: assert property (p_lower_off) else $error("lower select before write"); // [R5]

  property p_upper_early;
    @(posedge clock) disable iff (!arst_n)
      (cycTake && upperHit) |=> !upperSelN;
  endproperty
  a_upper_early: assert property (p_upper_early) else $error("upper select late"); // [R6]

  property p_periph_late;
    @(posedge clock) disable iff (!arst_n)
      (cycTake && perHit[0]) |=> lowPeriphSelN[0] ##1 !lowPeriphSelN[0];
  endproperty
  a_periph_late: assert property (p_periph_late) else $error("peripheral select timing"); // [R7]

  property p_release;
    @(posedge clock) disable iff (!arst_n)
      cycDone |=> upperSelN && lowerSelN && (&midSelN) && (&lowPeriphSelN);
  endproperty
  a_release: assert property (p_release) else $error("select held past cycle end"); // [R1]

  property p_suppress;
    @(posedge clock) disable iff (!arst_n)
      (!upperSelN && upper_memory_select_cfg[`CSW_BIT_DA] && cycBusy) |-> addrPhaseSuppress;
  endproperty
  a_suppress: assert property (p_suppress) else $error("address phase not suppressed"); // [R17]

  property p_col_block;
    @(posedge clock) disable iff (!arst_n)
      (cycTake && dramHit && perHit[1]) |=> colStrobeInhibit;
  endproperty
  a_col_block: assert property (p_col_block) else $error("column strobes not blocked"); // [R21]

  property p_bresp_hold;
    @(posedge clock) disable iff (!arst_n)
      (s_axi_bvalid && !s_axi_bready) |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bresp_hold: assert property (p_bresp_hold) else $error("write response dropped");

endmodule
`default_nettype wire

// [csw_mem_model.sv]
/*
  Far-side memory or peripheral model: answers the unit's selects with ready.
  Assumes active-low selects and a bench that routes ready to one pin.
*/
`timescale 1ns/10ps
`default_nettype none
module csw_mem_model (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic selN,
  input wire logic [3:0] lat,
  output logic rdy
);
  logic [3:0] cnt;
  // cycles since the select went low; slow devices answer late
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) cnt <= 4'h0;
    else if (selN) cnt <= 4'h0;
    else if (cnt != 4'hF) cnt <= cnt + 4'h1;
  end
  // lat zero acts as ready tied high, the harshest case for overlaps
  // bus width for a peripheral over dram is the software's job, not modelled
  assign rdy = (lat == 4'h0) | (!selN && cnt >= lat);
endmodule
`default_nettype wire

// [chip_select_wait_state_unit_test.sv]
/*
  Self-checking bench for the chip select and wait-state unit.
  Assumes the unit's defines header and package are compiled first.
*/
`timescale 1ns/10ps
`default_nettype none
`include "csw_defines.svh"
module chip_select_wait_state_unit_test;
  logic clock, arst_n, awvalid, wvalid, bready, arvalid, rready, awready, wready, arready;
  logic bvalid, rvalid, cycStart, pcbHit, cycDone, upperSelN, lowerSelN, adSup, useAsync, rdy;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd;
  logic [1:0] bresp, rresp, rr, hiN;
  logic [3:0] midN, loN, lat;
  logic [2:0] s;
  logic dram, colInh;
  logic [4:0] lp;
  csw_pkg::csw_cyc_s cycReq;
  int errTotal = 0, checked = 0, ticks = 0, n;
  localparam logic [11:0] aUm = {2'b00, `CSW_IDX_UPPER_MEMORY_SELECT_CFG, 2'b00};
  localparam logic [11:0] aLm = {2'b00, `CSW_IDX_LOWER_MEMORY_SELECT_CFG, 2'b00};
  initial begin
    clock = 0;
    forever #25 clock = ~clock;
  end
  csw_chip_select dut_u (.clock(clock), .arst_n(arst_n), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cycStart(cycStart), .cycReq(cycReq), .pcbHit(pcbHit), .dramHit(dram),
    .asyncReady(rdy & useAsync), .syncReady(rdy & !useAsync), .cycDone(cycDone),
    .cycBusy(), .upperSelN(upperSelN), .lowerSelN(lowerSelN), .midSelN(midN),
    .lowPeriphSelN(loN), .highPeriphSelN(hiN), .addrPhaseSuppress(adSup),
    .colStrobeInhibit(colInh));
  csw_mem_model mem_u (.clock(clock), .arst_n(arst_n),
    .selN(&{upperSelN, lowerSelN, midN, loN, hiN}), .lat(lat), .rdy(rdy));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errTotal++;
      $display("[ERR] t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task endOfTest;
    $display("checked %0d mismatches %0d", checked, errTotal);
    if (errTotal == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // both channels offered together, each released when taken
  task wr(input logic [11:0] a, input logic [15:0] d);
    awaddr <= a;
    wdata <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) bready <= 1'b0;
    end while (awvalid | wvalid | bready);
  endtask
  task rdt(input logic [11:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
      if (rvalid) begin
        rd = rdata;
        rr = rresp;
        rready <= 1'b0;
      end
    end while (rready);
  endtask
  // one bus cycle; n counts cycles to the final state, s holds selects in T2
  task cyc(input logic [19:0] a, input logic p);
    cycReq <= {a, 1'b0};
    pcbHit <= p;
    cycStart <= 1'b1;
    @(posedge clock);
    cycStart <= 1'b0;
    n = 0;
    do begin
      @(negedge clock);
      n++;
      if (n == 1) s = {upperSelN, lowerSelN, adSup};
      if (n == 2) lp = {colInh, loN};
    end while (cycDone !== 1'b1 && n < 40);
    @(posedge clock);
  endtask
  always @(posedge clock) begin
    ticks++;
    if (ticks == 20000) begin
      errTotal++;
      endOfTest();
    end
  end
  initial begin
    {arst_n, awvalid, wvalid, bready, arvalid, rready, cycStart, pcbHit, useAsync} = 9'h000;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h0000_0000;
    cycReq = '0;
    lat = 4'h0;
    dram = 1'b0;
    repeat (6) @(posedge clock);
    arst_n <= 1'b1;
    @(posedge clock);
    rdt(aUm);
    chk(rd, 32'h0000_F03B);
    rdt(aLm);
    chk(rd, 32'h0000_0000);
    rdt(12'h3FC);
    chk(rr, 2'h2);
    $display("test registers done");
    cyc(20'hF_0000, 1'b0);
    chk(n, 6);
    chk(s[2:1], 2'b01);
    cyc(20'h0_0000, 1'b0);
    chk({n[3:0], s[1]}, 5'h7);
    for (int w = 0; w < 4; w++) begin
      wr(aLm, 16'h0084 | w[15:0]);
      cyc(20'h0_0000, 1'b0);
      chk(n, 3 + w);
      chk(s, 3'b101);
    end
    cyc(20'h1_0000, 1'b0);
    chk(s[1], 1'b1);
    $display("test lower range done");
    cyc(20'hF_0000, 1'b1);
    chk(n, 3);
    lat <= 4'h8;
    useAsync <= 1'b1;
    wr(aUm, 16'hF03A);
    cyc(20'hF_0000, 1'b0);
    chk(n > 5, 1'b1);
    lat <= 4'h0;
    useAsync <= 1'b0;
    cyc(20'hF_0000, 1'b0);
    chk(n, 5);
    $display("test ready done");
    // peripherals in memory space at 80000h, high wait bit and 11b give 15 waits
    wr({2'b00, `CSW_IDX_SELECT_AUXILIARY_CFG, 2'b00}, 16'h0084);
    cyc(20'h8_0000, 1'b0);
    chk(lp[3:0], 4'hF);
    wr({2'b00, `CSW_IDX_PERIPHERAL_SELECT_BASE, 2'b00}, 16'h800F);
    cyc(20'h8_0000, 1'b0);
    chk(n, 18);
    chk(lp, 5'h0E);
    dram <= 1'b1;
    cyc(20'h8_0100, 1'b0);
    chk(lp, 5'h1D);
    dram <= 1'b0;
    $display("test peripheral done");
    endOfTest();
  end
endmodule
`default_nettype wire
